// [cmb_msg_buffer.sv]
// How it works
// R01 - software reaches buffers as plain memory words on a memory port
// R02 - software sets buffer area base and size; engine uses that region
// R03 - word 0 holds standard identifier at 12-2; bits 15-13 zero
// R04 - word 0 bit 1 is substitute remote request flag
// R05 - word 0 bit 0 selects extended identifier format
// R06 - word 1 bits 11-0 hold extended id 17-6; 15-12 zero
// R07 - word 2 holds extended id 5-0 at 15-10, remote flag at 9
// R08 - software writes zero to reserved bits 8 and 4 of word 2
// R09 - word 2 bits 3-0 hold length code; bits 7-5 zero
// R10 - words 3-6 hold payload, even byte low, odd byte high
// R11 - on receive, word 7 bits 12-8 get the matching filter code
// R12 - filter field written only for receive, ignored for transmit
// R13 - all receive words written before the buffer is reported full
`timescale 1ns/100ps
module cmb_msg_buffer (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    input wire logic ce,
    // buffer area placement
    input wire logic [cmb_pkg::BUF_AW-1:0] area_base,
    input wire logic [cmb_pkg::BUF_AW-1:0] area_count,
    // software memory port
    input wire logic sw_we,
    input wire logic [cmb_pkg::MEM_AW-1:0] sw_addr,
    input wire logic [cmb_pkg::WORD_W-1:0] sw_wdata,
    output logic [cmb_pkg::WORD_W-1:0] sw_rdata,
    // receive store request
    input wire logic rx_req,
    input wire logic [cmb_pkg::BUF_AW-1:0] rx_buf,
    input wire cmb_pkg::cmb_frame_s rx_frame,
    input wire logic [4:0] rx_matching_filter_code,
    output logic rx_full_pulse,
    output logic [cmb_pkg::BUF_AW-1:0] rx_full_buf,
    // transmit fetch request
    input wire logic tx_req,
    input wire logic [cmb_pkg::BUF_AW-1:0] tx_buf,
    output logic tx_valid,
    output cmb_pkg::cmb_frame_s tx_frame,
    // status
    output logic busy,
    output logic range_err
);
    cmb_mem_if mif ();
    cmb_pkg::cmb_state_e state_reg;
    logic [cmb_pkg::WIDX_W-1:0] idx_reg;
    logic [cmb_pkg::BUF_AW-1:0] buf_reg;
    cmb_pkg::cmb_frame_s frame_reg;
    logic [4:0] hit_reg;
    logic rd_pend_reg;
    logic [cmb_pkg::WIDX_W-1:0] rd_idx_reg;
    logic [cmb_pkg::WORD_W-1:0] wword;
    logic [cmb_pkg::WORD_W-1:0] rw;
    logic [cmb_pkg::MEM_AW-1:0] word_addr;
    logic in_range_rx;
    logic in_range_tx;

    // R01 plain memory
    cmb_mem u_mem (
        .clk(clk),
        .ce(ce),
        .a(mif.mem),
        .sw_we(sw_we),
        .sw_addr(sw_addr),
        .sw_wdata(sw_wdata),
        .sw_rdata(sw_rdata)
    );

    // ****************************************
    // address of the current word
    // ****************************************
    // R02 configured region
    assign word_addr = cmb_pkg::MEM_AW'({area_base, 3'h0}
        + {buf_reg, 3'h0} + idx_reg);
    assign in_range_rx = rx_buf < area_count;
    assign in_range_tx = tx_buf < area_count;

    // ****************************************
    // pack one word of a received frame
    // ****************************************
    always_comb begin
        wword = '0;
        case (idx_reg)
            cmb_pkg::W_STD: begin
                // R03 std identifier
                wword[cmb_pkg::STD_LSB +: 11] = frame_reg.std_identifier;
                // R04 srr flag
                wword[cmb_pkg::SRR_BIT] = frame_reg.srr;
                // R05 ide flag
                wword[cmb_pkg::IDE_BIT] = frame_reg.ide;
            end
            cmb_pkg::W_EXTH: begin
                // R06 ext high
                wword[cmb_pkg::EXTH_LSB +: 12] =
                    frame_reg.ext_identifier[17:6];
            end
            cmb_pkg::W_EXTL: begin
                // R07 ext low rtr
                wword[cmb_pkg::EXTL_LSB +: 6] =
                    frame_reg.ext_identifier[5:0];
                wword[cmb_pkg::RTR_BIT] = frame_reg.rtr;
                wword[cmb_pkg::RBHI_BIT] = frame_reg.reserved_proto_bit_hi;
                wword[cmb_pkg::RBLO_BIT] = frame_reg.reserved_proto_bit_lo;
                // R09 length code
                wword[cmb_pkg::DLC_LSB +: 4] = frame_reg.dlc;
            end
            cmb_pkg::W_HIT: begin
                // R11 filter code
                wword[cmb_pkg::HIT_LSB +: 5] = hit_reg;
            end
            default: begin
                // R10 payload pair
                wword = frame_reg.payload[
                    (idx_reg - cmb_pkg::W_DATA0) * 16 +: 16];
            end
        endcase
    end

    assign mif.we = ce && state_reg == cmb_pkg::ST_WRITE;
    assign mif.waddr = word_addr;
    assign mif.wdata = wword;
    assign mif.raddr = word_addr;

    // ****************************************
    // sequencer
    // ****************************************
    always_ff @(posedge clk) begin
        if (rst) begin
            state_reg <= cmb_pkg::ST_IDLE;
            idx_reg <= '0;
            buf_reg <= '0;
            hit_reg <= '0;
            rd_pend_reg <= 1'b0;
            rd_idx_reg <= '0;
            busy <= 1'b0;
            range_err <= 1'b0;
        end else if (ce) begin
            rd_pend_reg <= state_reg == cmb_pkg::ST_READ;
            rd_idx_reg <= idx_reg;
            range_err <= 1'b0;
            case (state_reg)
                cmb_pkg::ST_IDLE: begin
                    idx_reg <= '0;
                    if (rx_req) begin
                        buf_reg <= rx_buf;
                        hit_reg <= rx_matching_filter_code;
                        range_err <= !in_range_rx;
                        if (in_range_rx) begin
                            state_reg <= cmb_pkg::ST_WRITE;
                            busy <= 1'b1;
                        end
                    end else if (tx_req) begin
                        buf_reg <= tx_buf;
                        range_err <= !in_range_tx;
                        if (in_range_tx) begin
                            state_reg <= cmb_pkg::ST_READ;
                            busy <= 1'b1;
                        end
                    end
                end
                cmb_pkg::ST_WRITE: begin
                    idx_reg <= idx_reg + 3'h1;
                    // R13 full after last word
                    if (idx_reg == cmb_pkg::W_HIT) begin
                        state_reg <= cmb_pkg::ST_IDLE;
                        busy <= 1'b0;
                    end
                end
                cmb_pkg::ST_READ: begin
                    // R12 skip hit word on transmit
                    if (idx_reg == cmb_pkg::W_HIT - 3'h1) begin
                        state_reg <= cmb_pkg::ST_DONE;
                    end else begin
                        idx_reg <= idx_reg + 3'h1;
                    end
                end
                cmb_pkg::ST_DONE: begin
                    if (!rd_pend_reg) begin
                        state_reg <= cmb_pkg::ST_IDLE;
                        busy <= 1'b0;
                    end
                end
                default: begin
                    state_reg <= cmb_pkg::ST_IDLE;
                    busy <= 1'b0;
                end
            endcase
        end
    end

    // ****************************************
    // capture of the receive frame
    // ****************************************
    always_ff @(posedge clk) begin
        if (rst) begin
            frame_reg <= '0;
        end else if (ce && state_reg == cmb_pkg::ST_IDLE && rx_req) begin
            frame_reg <= rx_frame;
        end
    end

    // ****************************************
    // receive completion
    // ****************************************
    always_ff @(posedge clk) begin
        if (rst) begin
            rx_full_pulse <= 1'b0;
            rx_full_buf <= '0;
        end else if (ce) begin
            // R13 report after word 7
            rx_full_pulse <= state_reg == cmb_pkg::ST_WRITE
                && idx_reg == cmb_pkg::W_HIT;
            if (state_reg == cmb_pkg::ST_WRITE) begin
                rx_full_buf <= buf_reg;
            end
        end
    end

    // ****************************************
    // unpack transmit words
    // ****************************************
    assign rw = mif.rdata;
    always_ff @(posedge clk) begin
        if (rst) begin
            tx_frame <= '0;
            tx_valid <= 1'b0;
        end else if (ce) begin
            tx_valid <= rd_pend_reg && rd_idx_reg == cmb_pkg::W_HIT - 3'h1;
            if (rd_pend_reg) begin
                case (rd_idx_reg)
                    cmb_pkg::W_STD: begin
                        // R03 read identifier
                        tx_frame.std_identifier <=
                            rw[cmb_pkg::STD_LSB +: 11];
                        // R04 read srr
                        tx_frame.srr <= rw[cmb_pkg::SRR_BIT];
                        // R05 read ide
                        tx_frame.ide <= rw[cmb_pkg::IDE_BIT];
                    end
                    cmb_pkg::W_EXTH: begin
                        // R06 read ext high
                        tx_frame.ext_identifier[17:6] <=
                            rw[cmb_pkg::EXTH_LSB +: 12];
                    end
                    cmb_pkg::W_EXTL: begin
                        // R07 read ext low
                        tx_frame.ext_identifier[5:0] <=
                            rw[cmb_pkg::EXTL_LSB +: 6];
                        tx_frame.rtr <= rw[cmb_pkg::RTR_BIT];
                        // R08 passed as written
                        tx_frame.reserved_proto_bit_hi <=
                            rw[cmb_pkg::RBHI_BIT];
                        tx_frame.reserved_proto_bit_lo <=
                            rw[cmb_pkg::RBLO_BIT];
                        // R09 read length
                        tx_frame.dlc <= rw[cmb_pkg::DLC_LSB +: 4];
                    end
                    cmb_pkg::W_HIT: begin
                    end
                    default: begin
                        // R10 read payload pair
                        tx_frame.payload[
                            (rd_idx_reg - cmb_pkg::W_DATA0) * 16 +: 16] <= rw;
                    end
                endcase
            end
        end
    end
endmodule : cmb_msg_buffer

// [cmb_pkg.sv]
package cmb_pkg;
    // ****************************************
    // buffer geometry
    // ****************************************
    localparam int WORD_W = 16;
    localparam int WORDS = 8;
    localparam int BUF_AW = 8;
    localparam int MEM_AW = 9;
    localparam int WIDX_W = 3;
    localparam logic [BUF_AW-1:0] BASE_RESET = 8'h00;
    localparam logic [BUF_AW-1:0] COUNT_RESET = 8'h20;
    // ****************************************
    // word indices
    // ****************************************
    localparam logic [WIDX_W-1:0] W_STD = 3'h0;
    localparam logic [WIDX_W-1:0] W_EXTH = 3'h1;
    localparam logic [WIDX_W-1:0] W_EXTL = 3'h2;
    localparam logic [WIDX_W-1:0] W_DATA0 = 3'h3;
    localparam logic [WIDX_W-1:0] W_HIT = 3'h7;
    // ****************************************
    // field positions
    // ****************************************
    localparam int STD_LSB = 2;
    localparam int SRR_BIT = 1;
    localparam int IDE_BIT = 0;
    localparam int EXTH_LSB = 0;
    localparam int EXTL_LSB = 10;
    localparam int RTR_BIT = 9;
    localparam int RBHI_BIT = 8;
    localparam int RBLO_BIT = 4;
    localparam int DLC_LSB = 0;
    localparam int HIT_LSB = 8;

    typedef struct packed {
        logic [10:0] std_identifier;
        logic [17:0] ext_identifier;
        logic srr;
        logic ide;
        logic rtr;
        logic reserved_proto_bit_hi;
        logic reserved_proto_bit_lo;
        logic [3:0] dlc;
        logic [63:0] payload;
    } cmb_frame_s;

    typedef enum logic [1:0] {ST_IDLE, ST_WRITE, ST_READ, ST_DONE} cmb_state_e;
endpackage : cmb_pkg

// [cmb_mem_if.sv]
`timescale 1ns/100ps
interface cmb_mem_if;
    logic we;
    logic [cmb_pkg::MEM_AW-1:0] waddr;
    logic [cmb_pkg::WORD_W-1:0] wdata;
    logic [cmb_pkg::MEM_AW-1:0] raddr;
    logic [cmb_pkg::WORD_W-1:0] rdata;
    modport engine (output we, output waddr, output wdata, output raddr,
                    input rdata);
    modport mem (input we, input waddr, input wdata, input raddr,
                 output rdata);
endinterface : cmb_mem_if

// [cmb_mem.sv]
`timescale 1ns/100ps
module cmb_mem (
    // clocking
    input wire logic clk,
    input wire logic ce,
    // port a: engine
    cmb_mem_if.mem a,
    // port b: software
    input wire logic sw_we,
    input wire logic [cmb_pkg::MEM_AW-1:0] sw_addr,
    input wire logic [cmb_pkg::WORD_W-1:0] sw_wdata,
    output logic [cmb_pkg::WORD_W-1:0] sw_rdata
);
    logic [cmb_pkg::WORD_W-1:0] ram [0:(1<<cmb_pkg::MEM_AW)-1];

    // ****************************************
    // dual-port storage, engine write wins
    // ****************************************
    always_ff @(posedge clk) begin
        if (ce) begin
            if (sw_we && !(a.we && a.waddr == sw_addr)) begin
                ram[sw_addr] <= sw_wdata;
            end
            if (a.we) begin
                ram[a.waddr] <= a.wdata;
            end
            a.rdata <= ram[a.raddr];
            sw_rdata <= ram[sw_addr];
        end
    end
endmodule : cmb_mem

// [cmb_msg_buffer_props.sv]
`timescale 1ns/100ps
module cmb_msg_buffer_props (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    input wire logic ce,
    // requests
    input wire logic [cmb_pkg::BUF_AW-1:0] area_count,
    input wire logic rx_req,
    input wire logic [cmb_pkg::BUF_AW-1:0] rx_buf,
    input wire logic tx_req,
    input wire logic [cmb_pkg::BUF_AW-1:0] tx_buf,
    // answers
    input wire logic rx_full_pulse,
    input wire logic [cmb_pkg::BUF_AW-1:0] rx_full_buf,
    input wire logic tx_valid,
    input wire logic busy,
    input wire logic range_err
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    logic rx_take;
    logic tx_take;
    logic bad_idx;
    assign rx_take = ce && !busy && rx_req && rx_buf < area_count;
    assign tx_take = ce && !busy && tx_req && !rx_req && tx_buf < area_count;
    assign bad_idx = ce && !busy && (rx_req ? rx_buf >= area_count
        : tx_req && tx_buf >= area_count);
    chk_rx_busy_run: assert property (
        rx_take |=> busy [*8]) else $error("busy dropped during store");
    chk_rx_full_late: assert property (
        rx_take |-> ##1 !rx_full_pulse [*8] ##1 rx_full_pulse)
        else $error("full pulse not after eight word writes");
    chk_full_buf_idx: assert property (
        rx_take |-> ##9 rx_full_buf == $past(rx_buf, 9))
        else $error("full buffer index wrong");
    chk_tx_valid_time: assert property (
        tx_take |-> ##1 !tx_valid [*8] ##1 tx_valid)
        else $error("fetch answer timing wrong");
    chk_bad_idx_err: assert property (
        bad_idx |=> range_err && !busy) else $error("range error missing");
    chk_full_single: assert property (
        rx_full_pulse |=> !rx_full_pulse) else $error("full pulse too long");
    chk_valid_single: assert property (
        tx_valid |=> !tx_valid) else $error("valid pulse too long");
    chk_full_idle: assert property (
        rx_full_pulse |-> !busy && $past(busy))
        else $error("full pulse outside store end");
endmodule : cmb_msg_buffer_props
bind cmb_msg_buffer cmb_msg_buffer_props chk (.clk, .rst, .ce, .area_count,
    .rx_req, .rx_buf, .tx_req, .tx_buf, .rx_full_pulse, .rx_full_buf,
    .tx_valid, .busy, .range_err);

// [cmb_engine_model.sv]
`timescale 1ns/100ps
module cmb_engine_model (
    // clock and status
    input wire logic clk,
    input wire logic busy,
    input wire logic range_err,
    // requests
    output logic rx_req,
    output logic [7:0] rx_buf,
    output cmb_pkg::cmb_frame_s rx_frame,
    output logic [4:0] rx_matching_filter_code,
    output logic tx_req,
    output logic [7:0] tx_buf
);
    initial begin
        rx_req = 1'b0;
        tx_req = 1'b0;
        rx_buf = 8'h00;
        tx_buf = 8'h00;
        rx_frame = '0;
        rx_matching_filter_code = 5'h00;
    end
    // waits idle, holds request until taken or refused
    task automatic req(input logic is_rx, input logic [7:0] b,
            input cmb_pkg::cmb_frame_s f, input logic [4:0] c,
            output logic [1:0] res);
        int n;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (busy !== 1'b0 && n < 40);
        rx_req <= is_rx;
        tx_req <= !is_rx;
        rx_buf <= b;
        tx_buf <= b;
        rx_frame <= f;
        rx_matching_filter_code <= c;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (busy !== 1'b1 && range_err !== 1'b1 && n < 40);
        res = {range_err, busy};
        rx_req <= 1'b0;
        tx_req <= 1'b0;
        rx_buf <= ~b;
        tx_buf <= ~b;
        rx_frame <= ~f;
        rx_matching_filter_code <= ~c;
    endtask : req
endmodule : cmb_engine_model

// [can_message_buffer_format_test.sv]
`timescale 1ns/100ps
module can_message_buffer_format_test;
    typedef logic [127:0] cmb_wide_t;
    logic clk, rst, ce, sw_we, rx_req, tx_req, rx_full_pulse, tx_valid;
    logic busy, range_err, rd_go, rd_q1;
    logic [7:0] area_base, area_count, rx_full_buf, rx_buf, tx_buf;
    logic [8:0] sw_addr;
    logic [15:0] sw_wdata, sw_rdata, lf;
    logic [15:0] img[8];
    logic [4:0] rx_matching_filter_code;
    logic [4:0] cs[3];
    logic [1:0] res;
    cmb_pkg::cmb_frame_s rx_frame, tx_frame, fr;
    cmb_pkg::cmb_frame_s fs[3];
    cmb_wide_t exp_q[$];
    int err_total, n_compared;
    cmb_msg_buffer uut (.clk, .rst, .ce, .area_base, .area_count, .sw_we,
        .sw_addr, .sw_wdata, .sw_rdata, .rx_req, .rx_buf, .rx_frame,
        .rx_matching_filter_code, .rx_full_pulse, .rx_full_buf, .tx_req,
        .tx_buf, .tx_valid, .tx_frame, .busy, .range_err);
    cmb_engine_model eng (.clk, .busy, .range_err, .rx_req, .rx_buf,
        .rx_frame, .rx_matching_filter_code, .tx_req, .tx_buf);
    function automatic logic [15:0] lfsr(input logic [15:0] v);
        return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
    endfunction : lfsr
    function automatic logic [15:0] word_of(input cmb_pkg::cmb_frame_s f,
            input logic [4:0] c, input int i);
        case (i)
            0: return {3'h0, f.std_identifier, f.srr, f.ide};
            1: return {4'h0, f.ext_identifier[17:6]};
            2: return {f.ext_identifier[5:0], f.rtr, f.reserved_proto_bit_hi,
                3'h0, f.reserved_proto_bit_lo, f.dlc};
            7: return {3'h0, c, 8'h00};
            default: return f.payload[16*(i-3) +: 16];
        endcase
    endfunction : word_of
    task automatic tally_and_finish();
        $display("compared %0d mismatches %0d", n_compared, err_total);
        if (err_total == 0 && n_compared > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : tally_and_finish
    task automatic cmp(input cmb_wide_t got, input cmb_wide_t exp);
        n_compared++;
        if (got !== exp) begin
            err_total++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : cmp
    task automatic take(input cmb_wide_t got);
        if (exp_q.size() == 0) begin
            cmp(got, ~got);
        end else begin
            cmp(got, exp_q.pop_front());
        end
    endtask : take
    // ****************************************
    // result watcher
    // ****************************************
    always @(posedge clk) begin
        rd_q1 <= rd_go;
        if (rd_q1) take(cmb_wide_t'(sw_rdata));
        if (rx_full_pulse) take(cmb_wide_t'(rx_full_buf));
        if (tx_valid) take(cmb_wide_t'(tx_frame));
    end
    task automatic rnd_frame();
        cmb_wide_t w;
        w = '0;
        for (int i = 0; i < 7; i++) begin
            lf = lfsr(lf);
            w = {w[111:0], lf};
        end
        fr = cmb_pkg::cmb_frame_s'(w[101:0]);
        fr.dlc = 4'(lf % 9);
    endtask : rnd_frame
    task automatic sw_buf(input logic [7:0] b, input logic wr);
        for (int i = 0; i < 8; i++) begin
            @(posedge clk);
            sw_addr <= 9'((area_base + b) * 8 + i);
            sw_we <= wr;
            rd_go <= !wr;
            sw_wdata <= img[i];
        end
        @(posedge clk);
        sw_we <= 1'b0;
        rd_go <= 1'b0;
    endtask : sw_buf
    task automatic idle();
        int n;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (busy !== 1'b0 && n < 40);
        if (n >= 40) begin
            err_total++;
            tally_and_finish();
        end
        repeat (3) @(posedge clk);
    endtask : idle
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    initial begin
        repeat (20000) @(posedge clk);
        err_total++;
        tally_and_finish();
    end
    // ****************************************
    // main sequence
    // ****************************************
    initial begin
        rst = 1'b1;
        ce = 1'b1;
        area_base = 8'h05;
        area_count = 8'h04;
        sw_we = 1'b0;
        sw_addr = 9'h000;
        sw_wdata = 16'h0000;
        rd_go = 1'b0;
        lf = 16'hbbfb;
        repeat (16) @(posedge clk);
        rst <= 1'b0;
        for (int k = 0; k < 3; k++) begin
            rnd_frame();
            fs[k] = fr;
            cs[k] = lf[4:0];
            exp_q.push_back(cmb_wide_t'(3 - k));
            eng.req(1'b1, 8'(3 - k), fr, cs[k], res);
            cmp(cmb_wide_t'(res), 128'h1);
        end
        idle();
        for (int k = 0; k < 3; k++) begin
            for (int i = 0; i < 8; i++) begin
                exp_q.push_back(cmb_wide_t'(word_of(fs[k], cs[k], i)));
            end
            sw_buf(8'(3 - k), 1'b0);
        end
        eng.req(1'b1, area_count, fr, 5'h00, res);
        cmp(cmb_wide_t'(res), 128'h2);
        eng.req(1'b0, 8'hff, fr, 5'h00, res);
        cmp(cmb_wide_t'(res), 128'h2);
        rnd_frame();
        fr.reserved_proto_bit_hi = 1'b0;
        fr.reserved_proto_bit_lo = 1'b0;
        for (int i = 0; i < 8; i++) begin
            img[i] = word_of(fr, 5'h1f, i);
        end
        sw_buf(8'h00, 1'b1);
        exp_q.push_back(cmb_wide_t'(fr));
        eng.req(1'b0, 8'h00, fr, 5'h00, res);
        cmp(cmb_wide_t'(res), 128'h1);
        idle();
        // filter word of a transmit buffer left as software wrote it
        for (int i = 0; i < 8; i++) begin
            exp_q.push_back(cmb_wide_t'(img[i]));
        end
        sw_buf(8'h00, 1'b0);
        idle();
        cmp(cmb_wide_t'(exp_q.size()), 128'h0);
        tally_and_finish();
    end
endmodule : can_message_buffer_format_test
